// file: rtl/sbc_gp_consts.svh
// Summary of operation
// - Two 12-bit scratch registers, each read back through its own feedback view
// - Power-on loads register zero with type and version, flag bit 11 cleared
// - Any write to register zero sets the flag, whatever bit 11 carried
// - Flag reads zero while the code is held, one once user data is stored
// - Frame bits 15:14 address: code 10 is register zero, 11 is register one
// - Register zero access returns own feedback if bit 13 set, else system configuration
// - Register one access returns own feedback if bit 13 set, else physical layer control
// - Bit 12 set only reads; bit 12 clear also writes frame data
// - Data bits 10:0 of zero and 11:0 of one stored and returned unchanged
// - Power-on, start-up and restart apply per-field defaults; unlisted registers keep values
// - Reset cause 0000 at power-on, start-up never loads 1100 (keeps prior value), restricted after restart
// - Bus wake flag cleared at power-on, set on start-up by bus wake, restart keeps
// - Pin edge wake flag cleared at power-on, set on start-up by pin edge
// - Register one cleared at power-on only; start-up and restart keep it
`ifndef SBC_GP_CONSTS_SVH
`define SBC_GP_CONSTS_SVH
`define ADDR_HI 15
`define ADDR_LO 14
`define FEEDBACK_SELECT_BIT 13
`define READ_WITHOUT_WRITE_BIT 12
`define ID_FLAG_BIT 11
`define SCRATCH_ZERO_HI 10
`define ADDR_SCRATCH_ZERO 2'h2
`define ADDR_SCRATCH_ONE 2'h3
`define SCRATCH_ONE_RESET 12'h000
`define CAUSE_POWER_ON 4'h0
`define CAUSE_CODE_2 4'h2
`define CAUSE_CODE_C 4'hc
`define CAUSE_CODE_E 4'he
`endif

// file: rtl/sbc_gp_pkg.sv
package sbc_gp_pkg;
   typedef logic [1:0] frame_addr_t;
   typedef logic [11:0] reg_word_t;
   typedef logic [3:0] cause_t;
endpackage : sbc_gp_pkg

// file: rtl/mode_event_if.sv
`timescale 1ns/10ps
`default_nettype none
// Mode events toward the status keeper and its flags back
interface mode_event_if;
   import sbc_gp_pkg::*;
   logic startup;
   logic restart;
   logic lin_wake_cause;
   logic pin_wake_cause;
   cause_t cause_code;
   cause_t reset_cause_field;
   logic bus_wake_flag;
   logic pin_edge_wake_flag;
   modport source (output startup, restart, lin_wake_cause, pin_wake_cause, cause_code,
      input reset_cause_field, bus_wake_flag, pin_edge_wake_flag);
   modport keeper (input startup, restart, lin_wake_cause, pin_wake_cause, cause_code,
      output reset_cause_field, bus_wake_flag, pin_edge_wake_flag);
endinterface : mode_event_if
`default_nettype wire

// file: rtl/sbc_status_defaults.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_gp_consts.svh"
module sbc_status_defaults
   import sbc_gp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   mode_event_if.keeper ev
);
   logic legal_restart;

   // Restart may only leave one of four cause codes
   assign legal_restart = (ev.cause_code == `CAUSE_POWER_ON) || (ev.cause_code == `CAUSE_CODE_2) ||
      (ev.cause_code == `CAUSE_CODE_C) || (ev.cause_code == `CAUSE_CODE_E);

   // Reset cause field per mode entry
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ev.reset_cause_field <= `CAUSE_POWER_ON;
      else if (ev.startup)
      begin
         if (ev.cause_code != `CAUSE_CODE_C)
            ev.reset_cause_field <= ev.cause_code;
      end
      else if (ev.restart)
         ev.reset_cause_field <= legal_restart ? ev.cause_code : `CAUSE_POWER_ON;
   end

   // Wake flags: set only by start-up with matching cause, restart keeps them
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ev.bus_wake_flag <= 1'b0;
         ev.pin_edge_wake_flag <= 1'b0;
      end
      else if (ev.startup)
      begin
         if (ev.lin_wake_cause)
            ev.bus_wake_flag <= 1'b1;
         if (ev.pin_wake_cause)
            ev.pin_edge_wake_flag <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_startup_ok;
      ev.startup && (ev.cause_code != `CAUSE_CODE_C);
   endsequence

   chk_startup_cause_load: assert property (s_startup_ok |=> ev.reset_cause_field == $past(ev.cause_code))
      else $error("start-up cause not loaded");
   chk_startup_never_c: assert property (ev.startup |=> (ev.reset_cause_field != `CAUSE_CODE_C) ||
      ($past(ev.reset_cause_field) == `CAUSE_CODE_C))
      else $error("start-up produced code 1100");
   chk_restart_cause_legal: assert property (ev.restart && !ev.startup |=>
      (ev.reset_cause_field == `CAUSE_POWER_ON) || (ev.reset_cause_field == `CAUSE_CODE_2) ||
      (ev.reset_cause_field == `CAUSE_CODE_C) || (ev.reset_cause_field == `CAUSE_CODE_E))
      else $error("restart cause illegal");
   chk_bus_wake_set: assert property (ev.startup && ev.lin_wake_cause |=> ev.bus_wake_flag)
      else $error("bus wake flag not set");
   chk_bus_wake_restart: assert property (ev.restart && !ev.startup |=> $stable(ev.bus_wake_flag))
      else $error("restart changed bus wake flag");
   chk_pin_wake_set: assert property (ev.startup && ev.pin_wake_cause |=> ev.pin_edge_wake_flag)
      else $error("pin edge flag not set");
   chk_pin_wake_quiet: assert property (!ev.startup |=> $stable(ev.pin_edge_wake_flag))
      else $error("pin edge flag changed outside start-up");
endmodule : sbc_status_defaults
`default_nettype wire

// file: rtl/sbc_gp_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_gp_consts.svh"
module sbc_gp_regs
   import sbc_gp_pkg::*;
#(
   parameter logic [6:0] CHIP_TYPE = 7'h15, // Arbitrary value
   parameter logic [3:0] CHIP_VERSION = 4'h1 // Arbitrary value
)
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic frame_valid_i,
   input wire logic [15:0] frame_i,
   input wire logic [11:0] sys_cfg_fb_i,
   input wire logic [11:0] phy_ctrl_fb_i,
   input wire logic startup_i,
   input wire logic restart_i,
   input wire logic lin_wake_cause_i,
   input wire logic pin_wake_cause_i,
   input wire logic [3:0] cause_code_i,
   output logic reply_valid_o,
   output logic [11:0] reply_o,
   output logic id_overwritten_flag_o,
   output logic [10:0] scratch_zero_bits_o,
   output logic [11:0] scratch_one_bits_o,
   output logic [3:0] reset_cause_field_o,
   output logic bus_wake_flag_o,
   output logic pin_edge_wake_flag_o
);
   frame_addr_t frame_register_address;
   logic feedback_select;
   logic read_without_write;
   logic hit_zero;
   logic hit_one;
   logic next_flag;
   logic [10:0] next_zero;
   reg_word_t next_one;
   reg_word_t next_reply;

   mode_event_if ev ();

   // Frame fields, all inputs come from same-clock serial logic
   assign frame_register_address = frame_i[`ADDR_HI:`ADDR_LO];
   assign feedback_select = frame_i[`FEEDBACK_SELECT_BIT];
   assign read_without_write = frame_i[`READ_WITHOUT_WRITE_BIT];
   assign hit_zero = frame_valid_i && (frame_register_address == `ADDR_SCRATCH_ZERO);
   assign hit_one = frame_valid_i && (frame_register_address == `ADDR_SCRATCH_ONE);

   // Next register contents; a write to register zero always marks the code as overwritten
   always_comb
   begin
      next_flag = id_overwritten_flag_o;
      next_zero = scratch_zero_bits_o;
      next_one = scratch_one_bits_o;
      if (hit_zero && !read_without_write)
      begin
         next_flag = 1'b1;
         next_zero = frame_i[`SCRATCH_ZERO_HI:0];
      end
      if (hit_one && !read_without_write)
         next_one = frame_i[11:0];
   end

   // Reply mux shows contents as they stand after this access
   always_comb
   begin
      next_reply = reply_o;
      if (hit_zero)
         next_reply = feedback_select ? {next_flag, next_zero} : sys_cfg_fb_i;
      else if (hit_one)
         next_reply = feedback_select ? next_one : phy_ctrl_fb_i;
   end

   // Register zero and its flag; power-on loads the identification code
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         id_overwritten_flag_o <= 1'b0;
         scratch_zero_bits_o <= {CHIP_VERSION, CHIP_TYPE};
      end
      else
      begin
         id_overwritten_flag_o <= next_flag;
         scratch_zero_bits_o <= next_zero;
      end
   end

   // Register one; mode entries other than power-on leave it alone
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         scratch_one_bits_o <= `SCRATCH_ONE_RESET;
      else
         scratch_one_bits_o <= next_one;
   end

   // Reply word and its one-cycle valid
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reply_valid_o <= 1'b0;
         reply_o <= 12'h000;
      end
      else
      begin
         reply_valid_o <= hit_zero || hit_one;
         reply_o <= next_reply;
      end
   end

   // Status defaults kept in the smaller module
   assign ev.startup = startup_i;
   assign ev.restart = restart_i;
   assign ev.lin_wake_cause = lin_wake_cause_i;
   assign ev.pin_wake_cause = pin_wake_cause_i;
   assign ev.cause_code = cause_code_i;
   assign reset_cause_field_o = ev.reset_cause_field;
   assign bus_wake_flag_o = ev.bus_wake_flag;
   assign pin_edge_wake_flag_o = ev.pin_edge_wake_flag;

   sbc_status_defaults sbc_status_defaults_inst (
      .core_clk_i (core_clk_i),
      .rst_n_i (rst_n_i),
      .ev (ev.keeper)
   );

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_write_zero;
      hit_zero && !read_without_write;
   endsequence
   sequence s_read_zero_fb;
      hit_zero && feedback_select;
   endsequence

   chk_write_sets_flag: assert property (s_write_zero |=> id_overwritten_flag_o)
      else $error("write did not set flag");
   chk_flag_stays_set: assert property (id_overwritten_flag_o |=> id_overwritten_flag_o)
      else $error("flag fell back");
   chk_flag_read_after: assert property (s_write_zero ##[1:2] s_read_zero_fb |=> reply_o[`ID_FLAG_BIT])
      else $error("read after write misses flag");
   chk_zero_data_stored: assert property (s_write_zero |=> scratch_zero_bits_o == $past(frame_i[10:0]))
      else $error("register zero data lost");
   chk_read_only_keeps: assert property ((hit_zero || hit_one) && read_without_write |=>
      $stable(scratch_zero_bits_o) && $stable(scratch_one_bits_o))
      else $error("read-only frame wrote");
   chk_zero_cfg_view: assert property (hit_zero && !feedback_select |=> reply_o == $past(sys_cfg_fb_i))
      else $error("wrong view for register zero");
   chk_one_phy_view: assert property (hit_one && !feedback_select |=> reply_o == $past(phy_ctrl_fb_i))
      else $error("wrong view for register one");
   chk_one_own_view: assert property (hit_one && feedback_select |=> reply_o == scratch_one_bits_o)
      else $error("register one feedback wrong");
   chk_reply_valid_hit: assert property (frame_valid_i && frame_i[`ADDR_HI] |=> reply_valid_o)
      else $error("no reply for scratch address");
   chk_reply_valid_miss: assert property (!(hit_zero || hit_one) |=> !reply_valid_o)
      else $error("reply for foreign address");
   chk_modes_keep_one: assert property ((startup_i || restart_i) && !hit_one |=> $stable(scratch_one_bits_o))
      else $error("mode entry changed register one");
endmodule : sbc_gp_regs
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Serial host that issues one access frame at a time and takes the reply
module host_model
(
   input wire logic core_clk_i,
   input wire logic reply_valid_i,
   input wire logic [11:0] reply_i,
   output logic frame_valid_o,
   output logic [15:0] frame_o
);
   initial
   begin
      frame_valid_o = 1'b0;
      frame_o = 16'h0000;
   end
   // Frame pulse for one cycle, reply sampled in the cycle where it stands
   task automatic xfer(input logic [15:0] f, output logic got, output logic [11:0] word);
      @(posedge core_clk_i);
      frame_valid_o <= 1'b1;
      frame_o <= f;
      @(posedge core_clk_i);
      frame_valid_o <= 1'b0;
      frame_o <= ~f; // Released lines must not keep the last frame
      #1;
      got = reply_valid_i;
      word = reply_i;
   endtask : xfer
endmodule : host_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sbc_gp_pkg::*;
   localparam logic [6:0] TYPE_CODE = 7'h2a; // Arbitrary value
   localparam logic [3:0] VER_CODE = 4'h3; // Arbitrary value
   localparam logic [10:0] ID = {VER_CODE, TYPE_CODE};
   logic core_clk_i, rst_n_i, startup, restart, lin_wake, pin_wake, got;
   logic reply_valid, id_flag, bus_wake, pin_flag, frame_valid;
   logic [15:0] frame;
   logic [10:0] zero_bits;
   reg_word_t sys_fb, phy_fb, word, reply, one_bits;
   cause_t code, cause, exp_c;
   int miscompares, compares;
   sbc_gp_regs #(.CHIP_TYPE(TYPE_CODE), .CHIP_VERSION(VER_CODE)) sbc_gp_regs_inst (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .frame_valid_i(frame_valid), .frame_i(frame),
      .sys_cfg_fb_i(sys_fb), .phy_ctrl_fb_i(phy_fb), .startup_i(startup), .restart_i(restart),
      .lin_wake_cause_i(lin_wake), .pin_wake_cause_i(pin_wake), .cause_code_i(code),
      .reply_valid_o(reply_valid), .reply_o(reply), .id_overwritten_flag_o(id_flag),
      .scratch_zero_bits_o(zero_bits), .scratch_one_bits_o(one_bits), .reset_cause_field_o(cause),
      .bus_wake_flag_o(bus_wake), .pin_edge_wake_flag_o(pin_flag));
   host_model host_model_inst (.core_clk_i(core_clk_i), .reply_valid_i(reply_valid), .reply_i(reply),
      .frame_valid_o(frame_valid), .frame_o(frame));
   // Clock of 8 ns period
   initial
   begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // Mode entry pulse with its cause levels
   task automatic mode(input logic st, input logic rs, input logic lw, input logic pw, input cause_t c);
      @(posedge core_clk_i);
      startup <= st;
      restart <= rs;
      lin_wake <= lw;
      pin_wake <= pw;
      code <= c;
      @(posedge core_clk_i);
      startup <= 1'b0;
      restart <= 1'b0;
      #1;
   endtask : mode
   // Frame and compare of the reply word
   task automatic acc(input logic [15:0] f, input logic [11:0] exp);
      host_model_inst.xfer(f, got, word);
      chk(got, 1'b1);
      chk(word, exp);
   endtask : acc
   // Hang guard
   initial
   begin
      #200000;
      miscompares++;
      close_out();
   end
   // Main sequence
   initial
   begin
      miscompares = 0;
      compares = 0;
      rst_n_i = 1'b0;
      {startup, restart, lin_wake, pin_wake} = 4'h0;
      code = 4'h0;
      sys_fb = 12'h3c1;
      phy_fb = 12'h0e7;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk({id_flag, zero_bits}, {1'b0, ID});
      chk(one_bits, 12'h000);
      chk({cause, bus_wake, pin_flag, reply_valid}, 7'h00);
      acc(16'hb000, {1'b0, ID});
      chk(id_flag, 1'b0);
      acc(16'h9000, sys_fb);
      host_model_inst.xfer(16'h0fff, got, word);
      chk({got, zero_bits}, {1'b0, ID});
      acc(16'h85a5, sys_fb);
      chk({id_flag, zero_bits}, 12'hda5);
      acc(16'ha7ff, 12'hfff);
      acc(16'heabc, 12'habc);
      acc(16'hd123, phy_fb);
      acc(16'hf456, 12'habc);
      mode(1'b1, 1'b0, 1'b1, 1'b0, 4'h5);
      chk({cause, bus_wake, pin_flag}, 6'h16);
      mode(1'b1, 1'b0, 1'b0, 1'b1, 4'hc);
      chk({cause, bus_wake, pin_flag}, 6'h17);
      // Every restart code, legal ones kept and others cleared
      for (int i = 0; i < 16; i++)
      begin
         exp_c = (i inside {0, 2, 12, 14}) ? cause_t'(i) : 4'h0;
         mode(1'b0, 1'b1, 1'b0, 1'b0, cause_t'(i));
         chk({cause, bus_wake, pin_flag}, {exp_c, 2'b11});
      end
      chk({id_flag, zero_bits, one_bits}, 24'hfffabc);
      // Second power-on in mid-run
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk({id_flag, zero_bits, one_bits}, {1'b0, ID, 12'h000});
      chk({cause, bus_wake, pin_flag}, 6'h00);
      // Restart with wake causes must not set cleared flags
      mode(1'b0, 1'b1, 1'b1, 1'b1, 4'he);
      chk({cause, bus_wake, pin_flag}, 6'h38);
      // Start-up with code 1100 and no wake cause keeps everything
      mode(1'b1, 1'b0, 1'b0, 1'b0, 4'hc);
      chk({cause, bus_wake, pin_flag}, 6'h38);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
